/* File: hw/rx_back_end.sv */
// receive back end: calibration sequencer, gain loop, demodulator,
// post filter, slicer and bit timing recovery behind a wishbone slave
// assumes rssi code and limiter bits arrive asynchronously on pins
//
// Implementation choices: the register offsets and the Wishbone register port.
`timescale 1ns/1ns
module rx_back_end #(
  parameter int CAL_N = rxbe_pkg::CAL_CYCLES,
  parameter int OSR   = rxbe_pkg::OSR_DEF
) (
  // clock, reset, enable
  input  wire logic        CLK,
  input  wire logic        RESET_N,
  input  wire logic        CE,
  // wishbone slave
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [7:0]  WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic      [31:0] WB_DAT_O,
  output logic             WB_ACK_O,
  // analog side inputs
  input  wire logic [6:0]  RSSI_CODE,
  input  wire logic        I_LIM,
  input  wire logic        Q_LIM,
  // analog side controls
  output logic      [1:0]  IF_BW,
  output logic             CAL_BUSY,
  output logic      [8:0]  CAL_DIVIDER,
  output logic             FRONT_AMP_MODE,
  output logic             MIXER_LIN,
  output logic      [1:0]  FRONT_GAIN,
  output logic      [1:0]  IF_GAIN,
  output logic             OFFSET_CLK,
  // recovered data
  output logic             DATA_OUT,
  output logic             DATA_CLK
);
  import rxbe_pkg::*;
  localparam int PW = $clog2(OSR);
  localparam int CW = $clog2(CAL_N + 1);
  localparam logic [PW-1:0] PH_SAMPLE = PW'(OSR / 2);

  function automatic logic [31:0] wmerge(input logic [31:0] o, input logic [31:0] d,
                                         input logic [3:0] s);
    logic [31:0] m;
    m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    return (o & ~m) | (d & m);
  endfunction

  function automatic logic signed [19:0] lp_step(input logic signed [19:0] x,
                                                 input logic signed [19:0] y,
                                                 input logic [9:0] bw);
    logic signed [31:0] p;
    p = (32'(x) - 32'(y)) * 32'($signed({1'b0, bw}));
    return 20'(p >>> BW_SH);
  endfunction

  // bus and register file
  logic        ack_q, ack_d;
  logic [31:0] rdat_q, rdat_d, rd;
  logic [31:0] ifbw_q, ifbw_d, cal_r_q, cal_r_d, gain_q, gain_d;
  logic [31:0] agc_r_q, agc_r_d, clk_r_q, clk_r_d, dem_q, dem_d;
  logic [5:0]  idx;
  logic        wr, cal_go;
  // pins
  logic [8:0]  s1_q, s2_q, s3_q, pin_q, pin_d;
  logic [6:0]  lvl_q, lvl_d;
  // calibration
  cal_st_t     cal_q, cal_d;
  logic [CW-1:0] ccnt_q, ccnt_d;
  logic        busy_q, busy_d;
  // gain loop
  agc_st_t     agc_q, agc_d;
  logic [2:0]  step_q, step_d;
  logic [7:0]  pre_q, pre_d, wcnt_q, wcnt_d;
  logic [1:0]  fg_q, fg_d, ig_q, ig_d;
  logic        agc_en;
  // offset clock
  logic [3:0]  oc_q, oc_d;
  logic        ocl_q, ocl_d;
  // demodulator and timing recovery
  logic [15:0] os_q, os_d;
  logic        tick_q, tick_d;
  logic        ip_q, ip_d, qp_q, qp_d, moved, fwd, rev;
  logic signed [19:0] hi_q, hi_d, lo_q, lo_d, y1_q, y1_d, y2_q, y2_d;
  logic signed [19:0] avg_q, avg_d, x;
  logic        sl_q, sl_d, sp_q, sp_d, dat_q, dat_d, dclk_q, dclk_d;
  logic [PW-1:0] ph_q, ph_d;

  assign idx    = WB_ADR_I[7:2];
  assign wr     = WB_CYC_I & WB_STB_I & WB_WE_I & ack_q;
  assign cal_go = wr & (idx == R_CAL) & WB_SEL_I[0] & WB_DAT_I[F_CAL_GO];
  assign agc_en = gain_q[F_AGC_EN];

  always_comb
  begin
    rd = 32'h00000000;
    case (idx)
      R_IFBW:  rd = ifbw_q;
      R_CAL:   rd = cal_r_q;
      R_GAIN:  rd = gain_q;
      R_AGC:   rd = agc_r_q;
      R_CLK:   rd = clk_r_q;
      R_DEMOD: rd = dem_q;
      R_STAT:
      begin
        rd[F_LVL +: 7]  = lvl_q;
        rd[F_RIG +: 2]  = ig_q;
        rd[F_RFG +: 2]  = fg_q;
        rd[F_CORR +: 7] = gain_corr({fg_q, ig_q});
        rd[F_BUSY]      = busy_q;
      end
      default: rd = 32'h00000000;
    endcase
  end

  always_comb
  begin
    ack_d   = WB_CYC_I & WB_STB_I & ~ack_q;
    rdat_d  = ack_d ? rd : rdat_q;
    ifbw_d  = ifbw_q;
    cal_r_d = cal_r_q;
    gain_d  = gain_q;
    agc_r_d = agc_r_q;
    clk_r_d = clk_r_q;
    dem_d   = dem_q;
    if (wr)
    begin
      case (idx)
        R_IFBW:  ifbw_d  = wmerge(ifbw_q, WB_DAT_I, WB_SEL_I) & M_IFBW;
        R_CAL:   cal_r_d = wmerge(cal_r_q, WB_DAT_I, WB_SEL_I) & M_CAL;
        R_GAIN:  gain_d  = wmerge(gain_q, WB_DAT_I, WB_SEL_I) & M_GAIN;
        R_AGC:   agc_r_d = wmerge(agc_r_q, WB_DAT_I, WB_SEL_I) & M_AGC;
        R_CLK:   clk_r_d = wmerge(clk_r_q, WB_DAT_I, WB_SEL_I) & M_CLK;
        R_DEMOD: dem_d   = wmerge(dem_q, WB_DAT_I, WB_SEL_I) & M_DEMOD;
        default: ifbw_d  = ifbw_q;
      endcase
    end
  end

  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      ack_q   <= 1'b0;
      rdat_q  <= 32'h00000000;
      ifbw_q  <= RST_IFBW;
      cal_r_q <= RST_CAL;
      gain_q  <= RST_GAIN;
      agc_r_q <= RST_AGC;
      clk_r_q <= RST_CLK;
      dem_q   <= RST_DEMOD;
    end
    else if (CE)
    begin
      ack_q   <= ack_d;
      rdat_q  <= rdat_d;
      ifbw_q  <= ifbw_d;
      cal_r_q <= cal_r_d;
      gain_q  <= gain_d;
      agc_r_q <= agc_r_d;
      clk_r_q <= clk_r_d;
      dem_q   <= dem_d;
    end
  end

  // pin synchroniser: a change counts once stages two and three agree
  always_comb
  begin
    pin_d = (~(s2_q ^ s3_q) & s3_q) | ((s2_q ^ s3_q) & pin_q);
    lvl_d = (pin_q[6:0] > LVL_MAX) ? LVL_MAX : pin_q[6:0];
  end

  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      s1_q  <= 9'h000;
      s2_q  <= 9'h000;
      s3_q  <= 9'h000;
      pin_q <= 9'h000;
      lvl_q <= 7'h00;
    end
    else if (CE)
    begin
      s1_q  <= {I_LIM, Q_LIM, RSSI_CODE};
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      pin_q <= pin_d;
      lvl_q <= lvl_d;
    end
  end

  // calibration sequencer
  always_comb
  begin
    cal_d  = cal_q;
    ccnt_d = ccnt_q;
    case (cal_q)
      CAL_IDLE:
      begin
        if (cal_go)
        begin
          cal_d  = CAL_RUN;
          ccnt_d = '0;
        end
      end
      CAL_RUN:
      begin
        if (ccnt_q == CW'(CAL_N - 1))
          cal_d = CAL_IDLE;
        else
          ccnt_d = ccnt_q + CW'(1);
      end
      default: cal_d = CAL_IDLE;
    endcase
    busy_d = (cal_d == CAL_RUN);
  end

  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      cal_q  <= CAL_IDLE;
      ccnt_q <= '0;
      busy_q <= 1'b0;
    end
    else if (CE)
    begin
      cal_q  <= cal_d;
      ccnt_q <= ccnt_d;
      busy_q <= busy_d;
    end
  end

  // gain loop
  always_comb
  begin
    agc_d  = agc_q;
    step_d = step_q;
    pre_d  = pre_q;
    wcnt_d = wcnt_q;
    case (agc_q)
      AG_RUN:
      begin
        pre_d = 8'h00;
        wcnt_d = agc_r_q[F_DLY +: 8];
        if (agc_en && lvl_q > agc_r_q[F_UP +: 7] && step_q < STEP_MAX)
        begin
          step_d = step_q + 3'h1;
          agc_d  = AG_WAIT;
        end
        else if (agc_en && lvl_q < agc_r_q[F_LOW +: 7] && step_q != 3'h0)
        begin
          step_d = step_q - 3'h1;
          agc_d  = AG_WAIT;
        end
      end
      AG_WAIT:
      begin
        if (!agc_en)
          agc_d = AG_RUN;
        else if ({1'b0, pre_q} + 9'h001 >= {1'b0, clk_r_q[F_SEQ +: 8]})
        begin
          pre_d = 8'h00;
          if (wcnt_q <= 8'h01)
            agc_d = AG_RUN;
          else
            wcnt_d = wcnt_q - 8'h01;
        end
        else
          pre_d = pre_q + 8'h01;
      end
      default: agc_d = AG_RUN;
    endcase
    fg_d = agc_en ? step_front(step_d) : gain_q[F_FAG +: 2];
    ig_d = agc_en ? step_if(step_d) : gain_q[F_IFG +: 2];
  end

  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      agc_q  <= AG_RUN;
      step_q <= 3'h0;
      pre_q  <= 8'h00;
      wcnt_q <= 8'h00;
      fg_q   <= FG_H;
      ig_q   <= IG_H;
    end
    else if (CE)
    begin
      agc_q  <= agc_d;
      step_q <= step_d;
      pre_q  <= pre_d;
      wcnt_q <= wcnt_d;
      fg_q   <= fg_d;
      ig_q   <= ig_d;
    end
  end

  // offset correction clock
  always_comb
  begin
    oc_d  = oc_q + 4'h1;
    ocl_d = ocl_q;
    if (oc_q >= off_half(clk_r_q[F_OFF +: 2]))
    begin
      oc_d  = 4'h0;
      ocl_d = ~ocl_q;
    end
  end

  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      oc_q  <= 4'h0;
      ocl_q <= 1'b0;
    end
    else if (CE)
    begin
      oc_q  <= oc_d;
      ocl_q <= ocl_d;
    end
  end

  // demodulator, post filter, slicer, timing recovery
  assign moved = (pin_q[8] ^ ip_q) | (pin_q[7] ^ qp_q);
  assign fwd   = moved & (ip_q ^ pin_q[7]);
  assign rev   = moved & ~(ip_q ^ pin_q[7]);

  always_comb
  begin
    tick_d = 1'b0;
    os_d   = os_q + 16'h0001;
    if ({1'b0, os_q} + 17'h00001 >= {1'b0, clk_r_q[F_OS +: 16]})
    begin
      os_d   = 16'h0000;
      tick_d = 1'b1;
    end
    case (dem_q[F_DSEL +: 2])
      DEM_COR: x = hi_q - lo_q;
      DEM_LIN: x = fwd ? EDGE_W : (rev ? -EDGE_W : 20'sh00000);
      DEM_ASK: x = 20'($signed({1'b0, lvl_q}) <<< ASK_SH);
      default: x = 20'sh00000;
    endcase
    ip_d  = ip_q;
    qp_d  = qp_q;
    hi_d  = hi_q;
    lo_d  = lo_q;
    y1_d  = y1_q;
    y2_d  = y2_q;
    avg_d = avg_q;
    sl_d  = sl_q;
    sp_d  = sp_q;
    ph_d  = ph_q;
    dat_d = dat_q;
    dclk_d = 1'b0;
    if (tick_q)
    begin
      ip_d  = pin_q[8];
      qp_d  = pin_q[7];
      hi_d  = hi_q - (hi_q >>> LEAK_SH) + (fwd ? EDGE_W : 20'sh00000);
      lo_d  = lo_q - (lo_q >>> LEAK_SH) + (rev ? EDGE_W : 20'sh00000);
      y1_d  = y1_q + lp_step(x, y1_q, dem_q[F_PBW +: 10]);
      y2_d  = y2_q + lp_step(y1_q, y2_q, dem_q[F_PBW +: 10]);
      avg_d = avg_q + ((y2_q - avg_q) >>> AVG_SH);
      if (dem_q[F_DSEL +: 2] == DEM_COR)
        sl_d = (y2_q > 20'sh00000);
      else
        sl_d = (y2_q > avg_q);
      sp_d = sl_q;
      ph_d = ph_q + PW'(1);
      if (sl_q != sp_q)
      begin
        if (ph_q >= PH_SAMPLE)
          ph_d = ph_q + PW'(2);
        else if (ph_q != '0)
          ph_d = ph_q;
      end
      if (ph_q == PH_SAMPLE)
      begin
        dat_d  = sl_q;
        dclk_d = 1'b1;
      end
    end
  end

  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      os_q  <= 16'h0000;
      tick_q <= 1'b0;
      ip_q  <= 1'b0;
      qp_q  <= 1'b0;
      hi_q  <= 20'sh00000;
      lo_q  <= 20'sh00000;
      y1_q  <= 20'sh00000;
      y2_q  <= 20'sh00000;
      avg_q <= 20'sh00000;
      sl_q  <= 1'b0;
      sp_q  <= 1'b0;
      ph_q  <= '0;
      dat_q <= 1'b0;
      dclk_q <= 1'b0;
    end
    else if (CE)
    begin
      os_q  <= os_d;
      tick_q <= tick_d;
      ip_q  <= ip_d;
      qp_q  <= qp_d;
      hi_q  <= hi_d;
      lo_q  <= lo_d;
      y1_q  <= y1_d;
      y2_q  <= y2_d;
      avg_q <= avg_d;
      sl_q  <= sl_d;
      sp_q  <= sp_d;
      ph_q  <= ph_d;
      dat_q <= dat_d;
      dclk_q <= dclk_d;
    end
  end

  assign WB_DAT_O       = rdat_q;
  assign WB_ACK_O       = ack_q;
  assign IF_BW          = ifbw_q[1:0];
  assign CAL_BUSY       = busy_q;
  assign CAL_DIVIDER    = cal_r_q[F_CAL_DV +: 9];
  assign FRONT_AMP_MODE = gain_q[F_FAM];
  assign MIXER_LIN      = gain_q[F_MIX];
  assign FRONT_GAIN     = fg_q;
  assign IF_GAIN        = ig_q;
  assign OFFSET_CLK     = ocl_q;
  assign DATA_OUT       = dat_q;
  assign DATA_CLK       = dclk_q;

  // checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);

  sequence s_cal_req;
    CE && cal_q == CAL_IDLE && cal_go;
  endsequence
  sequence s_settle;
    CE && agc_q == AG_WAIT;
  endsequence

  a_cal_starts: assert property (s_cal_req |=> busy_q)
    else $error("calibration did not start");
  a_cal_length: assert property ($fell(busy_q) |-> $past(ccnt_q) == CW'(CAL_N - 1))
    else $error("calibration length wrong");
  a_gain_reduce: assert property (CE && agc_q == AG_RUN && agc_en
      && lvl_q > agc_r_q[F_UP +: 7] && step_q < STEP_MAX
      |=> step_q == $past(step_q) + 3'h1 && agc_q == AG_WAIT)
    else $error("gain not reduced");
  a_gain_raise: assert property (CE && agc_q == AG_RUN && agc_en
      && lvl_q < agc_r_q[F_LOW +: 7] && lvl_q <= agc_r_q[F_UP +: 7] && step_q != 3'h0
      |=> step_q == $past(step_q) - 3'h1)
    else $error("gain not raised");
  a_settle_hold: assert property (s_settle |=> step_q == $past(step_q))
    else $error("gain changed while settling");
  a_manual_gain: assert property (CE && !agc_en |=> IF_GAIN == $past(gain_q[F_IFG +: 2])
      && FRONT_GAIN == $past(gain_q[F_FAG +: 2]))
    else $error("manual gain not applied");
  a_auto_pair: assert property (agc_en && $past(agc_en) |-> FRONT_GAIN == step_front(step_q)
      && IF_GAIN == step_if(step_q))
    else $error("gain pair off ladder");
  a_bit_phase: assert property (DATA_CLK |-> $past(ph_q) == PH_SAMPLE && $past(tick_q))
    else $error("bit clock at wrong phase");
  a_zero_slice: assert property (CE && tick_q && dem_q[F_DSEL +: 2] == DEM_COR
      |=> sl_q == ($past(y2_q) > 20'sh00000))
    else $error("correlator slicer not at zero");
  a_ack_pulse: assert property (CE && WB_ACK_O |=> !WB_ACK_O)
    else $error("ack longer than one cycle");
endmodule

/* File: hw/rxbe_pkg.sv */
// constants, register map and gain ladder of the receive back end
// assumes a 100 MHz system clock that also stands in for the crystal
package rxbe_pkg;
  localparam int CLK_MHZ     = 100;
  localparam int CAL_TIME_US = 200;
  localparam int CAL_CYCLES  = CAL_TIME_US * CLK_MHZ;
  localparam int OSR_DEF     = 32;

  // register index = byte address / 4
  localparam logic [5:0] R_IFBW  = 6'h00;
  localparam logic [5:0] R_CAL   = 6'h01;
  localparam logic [5:0] R_GAIN  = 6'h02;
  localparam logic [5:0] R_AGC   = 6'h03;
  localparam logic [5:0] R_CLK   = 6'h04;
  localparam logic [5:0] R_DEMOD = 6'h05;
  localparam logic [5:0] R_STAT  = 6'h06;

  localparam logic [31:0] M_IFBW  = 32'h00000003;
  localparam logic [31:0] M_CAL   = 32'h000003FE;
  localparam logic [31:0] M_GAIN  = 32'h0000007F;
  localparam logic [31:0] M_AGC   = 32'h00FF7F7F;
  localparam logic [31:0] M_CLK   = 32'hFFFFFF03;
  localparam logic [31:0] M_DEMOD = 32'h00000FFF;

  localparam logic [31:0] RST_IFBW  = 32'h00000000;
  localparam logic [31:0] RST_CAL   = 32'h00000000;
  localparam logic [31:0] RST_GAIN  = 32'h0000001D;
  localparam logic [31:0] RST_AGC   = 32'h000A461E;
  localparam logic [31:0] RST_CLK   = 32'h00203200;
  localparam logic [31:0] RST_DEMOD = 32'h00000025;

  // field positions
  localparam int F_CAL_GO = 0;
  localparam int F_CAL_DV = 1;
  localparam int F_AGC_EN = 0;
  localparam int F_IFG    = 1;
  localparam int F_FAG    = 3;
  localparam int F_FAM    = 5;
  localparam int F_MIX    = 6;
  localparam int F_LOW    = 0;
  localparam int F_UP     = 8;
  localparam int F_DLY    = 16;
  localparam int F_OFF    = 0;
  localparam int F_SEQ    = 8;
  localparam int F_OS     = 16;
  localparam int F_DSEL   = 0;
  localparam int F_PBW    = 2;
  localparam int F_LVL    = 0;
  localparam int F_RIG    = 7;
  localparam int F_RFG    = 9;
  localparam int F_CORR   = 16;
  localparam int F_BUSY   = 24;

  // front gain states (codes 30, 10, 3, off) and if gain states
  localparam logic [1:0] FG_H  = 2'h3;
  localparam logic [1:0] FG_M  = 2'h2;
  localparam logic [1:0] FG_L  = 2'h1;
  localparam logic [1:0] FG_EL = 2'h0;
  localparam logic [1:0] IG_H  = 2'h2;
  localparam logic [1:0] IG_M  = 2'h1;
  localparam logic [1:0] IG_L  = 2'h0;
  localparam logic [2:0] STEP_MAX = 3'h5;
  localparam logic [6:0] LVL_MAX  = 7'h4F;

  localparam logic [1:0] DEM_LIN = 2'h0;
  localparam logic [1:0] DEM_COR = 2'h1;
  localparam logic [1:0] DEM_ASK = 2'h2;

  localparam logic signed [19:0] EDGE_W = 20'sh00100;
  localparam int LEAK_SH = 3;
  localparam int AVG_SH  = 6;
  localparam int BW_SH   = 10;
  localparam int ASK_SH  = 4;

  typedef enum logic [1:0] {CAL_IDLE = 2'b01, CAL_RUN = 2'b10} cal_st_t;
  typedef enum logic [1:0] {AG_RUN = 2'b01, AG_WAIT = 2'b10} agc_st_t;

  function automatic logic [1:0] step_front(input logic [2:0] s);
    case (s)
      3'h0:    return FG_H;
      3'h1,
      3'h2,
      3'h3:    return FG_M;
      3'h4:    return FG_L;
      default: return FG_EL;
    endcase
  endfunction

  function automatic logic [1:0] step_if(input logic [2:0] s);
    case (s)
      3'h0,
      3'h1:    return IG_H;
      3'h2:    return IG_M;
      default: return IG_L;
    endcase
  endfunction

  function automatic logic [6:0] gain_corr(input logic [3:0] fi);
    case (fi)
      {FG_H, IG_H}:  return 7'h00;
      {FG_M, IG_H}:  return 7'h18;
      {FG_M, IG_M}:  return 7'h2D;
      {FG_M, IG_L}:  return 7'h3F;
      {FG_L, IG_L}:  return 7'h5A;
      {FG_EL, IG_L}: return 7'h69;
      default:       return 7'h00;
    endcase
  endfunction

  // last count of each offset clock half period (half period minus one) for divide 4, 8, 16
  function automatic logic [3:0] off_half(input logic [1:0] c);
    case (c)
      2'h0:    return 4'h1;
      2'h1:    return 4'h3;
      default: return 4'h7;
    endcase
  endfunction
endpackage

/* File: tb/sig_source.sv */
// partner model of the analog side: signal level and limited i/q tone
// assumes quarter tone period in clock cycles given by QTR
`timescale 1ns/1ns
module sig_source #(
  parameter int QTR = 4
) (
  // clock and reset
  input  wire logic       CLK,
  input  wire logic       RESET_N,
  // tone control from bench
  input  wire logic [6:0] LEVEL,
  input  wire logic       UP,
  // limiter and level outputs
  output logic      [6:0] RSSI_CODE,
  output logic            I_LIM,
  output logic            Q_LIM
);
  logic [1:0] ph_q;
  logic [7:0] cnt_q;
  // rotation sense gives tone above or below if
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      ph_q  <= 2'h0;
      cnt_q <= 8'h00;
    end
    else if (cnt_q == 8'(QTR - 1))
    begin
      cnt_q <= 8'h00;
      ph_q  <= UP ? ph_q + 2'h1 : ph_q - 2'h1;
    end
    else
      cnt_q <= cnt_q + 8'h01;
  end
  assign I_LIM     = ph_q[1];
  assign Q_LIM     = ph_q[1] ^ ph_q[0];
  assign RSSI_CODE = LEVEL;
endmodule

/* File: tb/tb_top.sv */
// testbench of the receive back end: wishbone tasks and directed tests
// assumes calibration shortened to 50 cycles and 32x oversampling
`timescale 1ns/1ns
`define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin err_total++; \
  $display("MISMATCH %s exp %0h got %0h", n, e, s); end end
module tb_top;
  import rxbe_pkg::*;
  logic        CLK;
  logic        RESET_N;
  logic        cyc;
  logic        stb;
  logic        we;
  logic [7:0]  adr;
  logic [31:0] wd;
  logic [3:0]  sel;
  logic [31:0] rd;
  logic        ack;
  logic [6:0]  level;
  logic        up;
  logic [6:0]  rssi;
  logic        i_lim;
  logic        q_lim;
  logic [1:0]  if_bw;
  logic        busy;
  logic [8:0]  cdiv;
  logic        fmode;
  logic        mix;
  logic [1:0]  fg;
  logic [1:0]  ig;
  logic        oclk;
  logic        dout;
  logic        dclk;
  logic [31:0] q;
  logic        d1;
  int          err_total;
  int          samples_checked;
  int          cycles;
  int          n;
  int          i;
  logic [31:0] rst_tab [6];

  rx_back_end #(.CAL_N(50), .OSR(32)) i_rx_back_end (
    .CLK(CLK), .RESET_N(RESET_N), .CE(1'b1),
    .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
    .WB_SEL_I(sel), .WB_DAT_I(wd), .WB_DAT_O(rd), .WB_ACK_O(ack),
    .RSSI_CODE(rssi), .I_LIM(i_lim), .Q_LIM(q_lim), .IF_BW(if_bw),
    .CAL_BUSY(busy), .CAL_DIVIDER(cdiv), .FRONT_AMP_MODE(fmode),
    .MIXER_LIN(mix), .FRONT_GAIN(fg), .IF_GAIN(ig), .OFFSET_CLK(oclk),
    .DATA_OUT(dout), .DATA_CLK(dclk));
  sig_source #(.QTR(4)) i_sig_source (
    .CLK(CLK), .RESET_N(RESET_N), .LEVEL(level), .UP(up),
    .RSSI_CODE(rssi), .I_LIM(i_lim), .Q_LIM(q_lim));

  always #5 CLK = ~CLK;

  task tally_and_finish;
    $display("checked %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  always @(posedge CLK)
  begin
    cycles++;
    if (cycles > 60000)
    begin
      err_total++;
      tally_and_finish();
    end
  end

  // one classic cycle; request held until ack is sampled high at a rising edge
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    sel <= 4'hF;
    adr <= a;
    wd  <= d;
    do @(posedge CLK); while (ack !== 1'b1);
    q = rd;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
    sel <= 4'h0;
  endtask

  // cycles between two rising edges of data clock or offset clock
  task gap(input logic w);
    int k;
    int t0;
    logic p;
    logic s;
    n = -1;
    t0 = -1;
    p = 1'b1;
    for (k = 0; k < 400 && n < 0; k++)
    begin
      @(negedge CLK);
      s = w ? dclk : oclk;
      if (s === 1'b1 && p !== 1'b1)
      begin
        if (t0 >= 0)
          n = k - t0;
        else
          t0 = k;
      end
      p = s;
    end
  endtask

  initial
  begin
    CLK = 1'b0;
    RESET_N = 1'b0;
    {cyc, stb, we, sel, adr, wd} = '0;
    level = 7'h32;
    up = 1'b1;
    err_total = 0;
    samples_checked = 0;
    cycles = 0;
    rst_tab = '{RST_IFBW, RST_CAL, RST_GAIN, RST_AGC, RST_CLK, RST_DEMOD};
    repeat (20) @(posedge CLK);
    RESET_N <= 1'b1;
    repeat (30) @(posedge CLK);
    for (i = 0; i < 6; i++)
    begin
      xfer(1'b0, 8'(i * 4), 32'h0);
      `CHK("reset reg", rst_tab[i], q)
    end
    `CHK("front gain", FG_H, fg)
    `CHK("if gain", IG_H, ig)
    xfer(1'b1, 8'h1C, 32'hFFFFFFFF);
    xfer(1'b0, 8'h1C, 32'h0);
    `CHK("unmapped", 32'h0, q)
    xfer(1'b1, 8'h00, 32'h2);
    @(negedge CLK);
    `CHK("if bw", 2'h2, if_bw)
    xfer(1'b1, 8'h04, 32'h14B);
    n = 0;
    for (i = 0; i < 200; i++)
    begin
      @(negedge CLK);
      if (busy === 1'b1)
        n++;
    end
    `CHK("cal cycles", 50, n)
    `CHK("cal divider", 9'h0A5, cdiv)
    xfer(1'b0, 8'h04, 32'h0);
    `CHK("cal reg", 32'h14A, q)
    for (i = 0; i < 3; i++)
    begin
      xfer(1'b1, 8'h10, 32'h00010100 | i);
      gap(1'b0);
      `CHK("offset period", 4 << i, n)
    end
    gap(1'b1);
    `CHK("data clk period", 32, n)
    xfer(1'b1, 8'h0C, 32'h0001461E);
    level <= 7'h7F;
    repeat (300) @(posedge CLK);
    `CHK("front gain low", FG_EL, fg)
    `CHK("if gain low", IG_L, ig)
    xfer(1'b0, 8'h18, 32'h0);
    `CHK("level clamp", LVL_MAX, q[6:0])
    `CHK("correction", 7'h69, q[22:16])
    `CHK("stat gains", {FG_EL, IG_L}, q[10:7])
    level <= 7'h0A;
    repeat (300) @(posedge CLK);
    xfer(1'b0, 8'h18, 32'h0);
    `CHK("correction hi", 7'h00, q[22:16])
    `CHK("level low", 7'h0A, q[6:0])
    xfer(1'b1, 8'h08, 32'h6A);
    repeat (4) @(posedge CLK);
    `CHK("manual gains", {FG_L, IG_M, 2'h3}, {fg, ig, fmode, mix})
    for (i = 2; i >= 0; i--)
    begin
      xfer(1'b1, 8'h14, 32'h24 | i);
      xfer(1'b0, 8'h14, 32'h0);
      `CHK("demod select", 2'(i), q[1:0])
    end
    xfer(1'b1, 8'h14, 32'h25);
    repeat (1500) @(posedge CLK);
    d1 = dout;
    `CHK("tone up", 1'b1, d1)
    up <= 1'b0;
    repeat (1500) @(posedge CLK);
    `CHK("tone decision", ~d1, dout)
    tally_and_finish();
  end
endmodule
